/* dv/mcu_model.sv */
// Companion controller model that collects recovered bits
`timescale 1ns/1ps
module mcu_model
(
    input  logic       hclk,
    input  logic       rclk,
    input  logic       rdata,
    output logic [7:0] shreg
);
    logic last;
    initial shreg = 8'h00;
    initial last = 1'b0;
    // Shift in the data bit on each rise of the recovered clock
    always @(posedge hclk)
    begin
        last <= rclk;
        if (rclk && !last)
            shreg <= {shreg[6:0], rdata};
    end
endmodule

/* dv/rx_ctrl_asserts.sv */
// Port assertions for the receiver sync and correction block
`timescale 1ns/1ps
module rx_ctrl_asserts
(
    input logic        hclk,
    input logic        hresetn,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic [31:0] hrdata,
    input logic        hreadyout,
    input logic        hresp,
    input logic [2:0]  mode_state,
    input logic        temp_adc_select,
    input logic        timeout_irq
);
    logic        take;
    logic        rd_unm;
    logic        wr_to;
    logic [11:0] tcnt;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Accepted address phase
    assign take = hsel && htrans[1] && hready;
    // Unmapped reads, timeout writes and measurement length
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_unm <= 1'b0;
            wr_to  <= 1'b0;
            tcnt   <= 12'h000;
        end
        else
        begin
            rd_unm <= take && !hwrite && haddr[7:0] >= 8'h24;
            wr_to  <= take && hwrite && haddr[7:0] == 8'h20;
            tcnt   <= temp_adc_select ? tcnt + 12'h001 : 12'h000;
        end
    end
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_unmapped_zero: assert property (rd_unm |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_mode_legal: assert property (
        mode_state != 3'h5 && mode_state != 3'h6)
        else $error("illegal mode state");
    a_temp_mode: assert property (
        $rose(temp_adc_select) |-> $past(mode_state) inside {3'h1, 3'h2})
        else $error("temp start in wrong mode");
    a_temp_bound: assert property (temp_adc_select |-> tcnt < 12'h7D0)
        else $error("temp too long");
    a_timeout_rx: assert property ($rose(timeout_irq) |-> $past(mode_state) == 3'h4)
        else $error("timeout outside receive");
    a_irq_sticky: assert property ($fell(timeout_irq) |-> $past(wr_to))
        else $error("timeout flag self cleared");
    c_temp_done: cover property ($fell(temp_adc_select));
    c_timeout: cover property ($rose(timeout_irq));
    c_unmapped: cover property (rd_unm);
endmodule

/* dv/tb_receiver_sync_afc_control.sv */
// Self-checking bench for the receiver sync and correction block
`timescale 1ns/1ps
`include "receiver_sync_afc_defines.vh"
module tb_receiver_sync_afc_control;
    logic        hclk, hresetn, hsel, hwrite, fsk_data, flag, rd_ph;
    logic [1:0]  htrans;
    logic [7:0]  rssi, temp_sensor;
    logic [15:0] ferr;
    logic [23:0] car;
    logic [31:0] haddr, hwdata;
    logic [63:0] m;
    logic [63:0] q[$];
    wire         hreadyout, hresp, ook_data, rclk, rdata, temp_sel, tirq;
    wire  [2:0]  mode;
    wire  [7:0]  bw, mbyte;
    wire  [31:0] hrdata;
    int          fail_count, total_checks, n;
    receiver_sync_afc_control receiver_sync_afc_control_inst
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rssi(rssi), .fsk_data(fsk_data),
        .freq_error_in(ferr), .temp_sensor(temp_sensor),
        .signal_level_threshold_flag(flag), .ook_data(ook_data),
        .recovered_clock_pin(rclk), .recovered_data(rdata),
        .active_bandwidth(bw), .mode_state(mode),
        .temp_adc_select(temp_sel), .timeout_irq(tirq)
    );
    mcu_model mcu_model_inst (.hclk(hclk), .rclk(rclk), .rdata(rdata), .shreg(mbyte));
    // Clock of 50 ns
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic wrap_up;
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        chk(k < 50, 1);
        if (k >= 50) wrap_up();
    endtask
    // One bus transfer: address phase, then data phase
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wt_rdy();
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        wt_rdy();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic md(input logic [7:0] v);
        wr(`ADDR_OP_MODE, {24'h0, v});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        q.push_back({k, e});
        @(posedge hclk);
        xfer(a, 1'b0, 32'h0);
    endtask
    task automatic rdc(input logic [15:0] d, input logic [23:0] o);
        car = car - {{8{d[15]}}, d} - o;
        rd(`ADDR_CARRIER, car, 32'hFFFFFF);
    endtask
    task automatic meas(input bit t, input int lo, input int hi);
        n = 0;
        while ((t ? temp_sel !== 1'b0 : tirq !== 1'b1) && n < 2100)
        begin
            @(posedge hclk);
            n++;
        end
        chk(n >= lo && n <= hi, 1);
        if (n >= 2100) wrap_up();
    endtask
    // Compare read data with the oldest note
    always @(posedge hclk)
    begin
        if (rd_ph && hreadyout === 1'b1)
        begin
            m = q.pop_front();
            chk(hrdata & m[63:32], m[31:0]);
        end
        rd_ph <= hsel && htrans[1] && hreadyout && !hwrite;
    end
    // Main sequence
    initial
    begin
        {hresetn, hsel, hwrite, fsk_data, flag, rd_ph} = 6'h0;
        {htrans, rssi, temp_sensor, ferr, haddr, hwdata, car} = 0;
        n = $urandom(32'h3FA4);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`ADDR_OP_MODE, 32'h101, 32'h71F);
        rd(`ADDR_BIT_RATE, 32'h0680, 32'hFFFF);
        rd(`ADDR_OOK, 32'h10C, 32'h3FF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        wr(`ADDR_BIT_RATE, 32'h8);
        wr(`ADDR_OOK, 32'h040);
        for (int i = 0; i < 4; i++)
        begin
            rssi <= $urandom % 128;
            repeat (3) @(posedge hclk);
            chk(ook_data, rssi >= 8'h40);
        end
        wr(`ADDR_OOK, 32'h140);
        rssi <= 8'h80;
        repeat (4) @(posedge hclk);
        rssi <= 8'h75;
        repeat (2) @(posedge hclk);
        chk(ook_data, 1);
        rssi <= 8'h70;
        repeat (2) @(posedge hclk);
        chk(ook_data, 0);
        wr(`ADDR_OOK, 32'h240);
        repeat (60) @(posedge hclk);
        rssi <= 8'h50;
        repeat (2) @(posedge hclk);
        chk(ook_data, 0);
        $display("slicer test done");
        for (int i = 0; i < 5; i++)
        begin
            wr(`ADDR_OP_MODE, 32'h10 | i);
            rd(`ADDR_OP_MODE, i << 8, 32'h700);
        end
        md(8'h18);
        rd(`ADDR_OP_MODE, 32'h700, 32'h700);
        md(8'h11);
        md(8'h04);
        chk(mode == 3'h4, 0);
        repeat (200) @(posedge hclk);
        chk(mode, 3'h4);
        $display("mode test done");
        md(8'h11);
        temp_sensor <= $urandom;
        wr(`ADDR_TEMP, 32'h1);
        rd(`ADDR_TEMP, 32'h2, 32'h2);
        meas(1, 0, 2099);
        rd(`ADDR_TEMP, {16'h0, ~temp_sensor, 8'h0}, 32'hFF02);
        md(8'h14);
        wr(`ADDR_TEMP, 32'h1);
        repeat (2) @(posedge hclk);
        chk(temp_sel, 0);
        $display("temperature test done");
        wr(`ADDR_OFFSET, 32'h3CA500);
        wr(`ADDR_CARRIER, 32'h100000);
        ferr <= $urandom;
        wr(`ADDR_CORR_CTRL, 32'h10);
        repeat (40) @(posedge hclk);
        rd(`ADDR_RESULT, {16'h0, ferr}, 32'hFFFF);
        wr(`ADDR_CORR_CTRL, 32'h1);
        repeat (2) @(posedge hclk);
        chk(bw, 8'hA5);
        repeat (40) @(posedge hclk);
        chk(bw, 8'h3C);
        rdc(ferr, 24'hF00000);
        wr(`ADDR_OFFSET, 32'h3CA503);
        wr(`ADDR_CORR_CTRL, 32'h9);
        repeat (80) @(posedge hclk);
        rdc(ferr, 24'h000018);
        wr(`ADDR_OFFSET, 32'h3CA500);
        wr(`ADDR_CORR_CTRL, 32'h2);
        md(8'h11);
        md(8'h14);
        repeat (40) @(posedge hclk);
        rdc(ferr, 24'h0);
        car = car + {{8{ferr[15]}}, ferr};
        wr(`ADDR_CORR_CTRL, 32'h6);
        md(8'h11);
        ferr <= $urandom;
        md(8'h14);
        repeat (40) @(posedge hclk);
        rdc(ferr, 24'h0);
        $display("correction test done");
        wr(`ADDR_CORR_CTRL, 32'h20);
        for (int i = 0; i < 36; i++)
        begin
            fsk_data <= (i < 24) ? i[0] : 1'b1;
            repeat (8) @(posedge hclk);
        end
        chk(mbyte, 8'hFF);
        wr(`ADDR_CORR_CTRL, 32'h60);
        fsk_data <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({rclk, rdata}, 2'h0);
        $display("bit sync test done");
        md(8'h11);
        wr(`ADDR_TIMEOUT, 32'h0201);
        md(8'h14);
        meas(0, 112, 136);
        md(8'h11);
        md(8'h14);
        wr(`ADDR_TIMEOUT, 32'h10201);
        rd(`ADDR_TIMEOUT, 32'h0201, 32'h1FFFF);
        flag <= 1'b1;
        meas(0, 240, 264);
        $display("timeout test done");
        wrap_up();
    end
endmodule
bind receiver_sync_afc_control rx_ctrl_asserts rx_ctrl_asserts_inst
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mode_state(mode_state), .temp_adc_select(temp_adc_select),
    .timeout_irq(timeout_irq)
);

/* logic/bit_sync.v */
// Bit synchronizer: realigns on data edges, samples mid-bit
`timescale 1ns/1ps
module bit_sync
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        enable,
    input  wire [15:0] period,
    input  wire        data_in,
    output reg         data_out,
    output reg         clk_out
);
    reg        last;
    reg [15:0] phase;
    wire       edge_seen;
    wire [15:0] half;

    assign edge_seen = data_in ^ last;
    assign half      = {1'b0, period[15:1]};

    // Phase counter realigned on each transition, samples at mid-bit
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            last     <= 1'b0;
            phase    <= 16'h0000;
            data_out <= 1'b0;
            clk_out  <= 1'b0;
        end
        else if (!enable)
        begin
            last    <= data_in;
            phase   <= 16'h0000;
            clk_out <= 1'b0;
        end
        else
        begin
            last <= data_in;
            if (edge_seen)
                phase <= 16'h0001;
            else if (phase >= period - 16'h0001)
                phase <= 16'h0000;
            else
                phase <= phase + 16'h0001;
            if (phase == half)
            begin
                data_out <= data_in;
                clk_out  <= 1'b1;
            end
            else if (phase == 16'h0000 || edge_seen)
                clk_out <= 1'b0;
        end
    end
endmodule

/* logic/receiver_sync_afc_control.v */
// Receiver slicer, bit sync, correction, temperature, timeout, modes
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "receiver_sync_afc_defines.vh"
module receiver_sync_afc_control
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [7:0]  rssi,
    input  wire        fsk_data,
    input  wire signed [15:0] freq_error_in,
    input  wire [7:0]  temp_sensor,
    input  wire        signal_level_threshold_flag,
    output reg         ook_data,
    output reg         recovered_clock_pin,
    output reg         recovered_data,
    output reg  [7:0]  active_bandwidth,
    output reg  [2:0]  mode_state,
    output reg         temp_adc_select,
    output reg         timeout_irq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [4:0]  op_mode;
    reg [15:0] bit_rate_register;
    reg [12:0] ook_cfg;
    reg [6:0]  corr_ctrl;
    reg signed [15:0] freq_error_result;
    reg signed [15:0] freq_correction_value;
    reg [23:0] carrier;
    reg [23:0] offset_cfg;
    reg        temp_measure_running;
    reg [7:0]  temp_result;
    reg [15:0] timeout_cfg;
    reg        wr_pend;
    reg [7:0]  wr_addr;
    reg [7:0]  peak;
    reg [7:0]  avg;
    reg [15:0] bit_cnt;
    reg        bit_tick;
    reg [2:0]  eval_cnt;
    reg        corr_busy;
    reg        fei_busy;
    reg        second_pass;
    reg [2:0]  last_mode;
    reg [11:0] seq_cnt;
    reg [10:0] temp_cnt;
    reg [11:0] to_cnt;
    reg        to_phase;
    reg        thr_last;
    reg [7:0]  next_thr;
    reg [7:0]  next_floor;
    reg [31:0] next_rdata;
    wire       ahb_go;
    wire [15:0] period;
    wire [7:0] floor_thr;
    wire [1:0] ook_threshold_select;
    wire       sync_en;
    wire       sync_data;
    wire       sync_clk;
    wire       demod;
    wire       enter_rx;
    wire       launch;
    wire signed [15:0] low_index_term;
    wire [2:0] target;
    wire       temp_ok;

    assign ahb_go    = hsel & htrans[1] & hready;
    assign period    = (bit_rate_register == 16'h0000) ? 16'h0001 : bit_rate_register;
    assign floor_thr = ook_cfg[7:0];
    assign ook_threshold_select = ook_cfg[`OOK_SEL_LO+1:`OOK_SEL_LO];
    assign demod     = ook_cfg[`OOK_OOK_MOD] ? ook_data : fsk_data;
    assign enter_rx  = (mode_state == `MODE_RX) & (last_mode != `MODE_RX);
    assign launch    = (corr_ctrl[`CC_AUTO] & enter_rx) | (!corr_ctrl[`CC_AUTO] & wr_pend
                       & (wr_addr == `ADDR_CORR_CTRL) & hwdata[`CC_START]);
    assign low_index_term = {{5{offset_cfg[7]}}, offset_cfg[7:0], 3'h0};
    assign target    = op_mode[`OM_LISTEN] ? `MODE_LISTEN : op_mode[2:0];
    assign temp_ok   = (mode_state == `MODE_STANDBY) | (mode_state == `MODE_SYNTH);
    // Packet mode always synchronizes; continuous mode may bypass
    assign sync_en   = !corr_ctrl[`CC_CONT] | !corr_ctrl[`CC_SYNC_OFF];

    // ----------------------------------------
    // Bit synchronizer
    // ----------------------------------------
    bit_sync u_bit_sync
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .enable   (sync_en),
        .period   (period),
        .data_in  (demod),
        .data_out (sync_data),
        .clk_out  (sync_clk)
    );

    // Recovered stream or raw data on the clock and data pins
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            recovered_data      <= 1'b0;
            recovered_clock_pin <= 1'b0;
        end
        else if (sync_en)
        begin
            recovered_data      <= sync_data;
            recovered_clock_pin <= sync_clk;
        end
        else
        begin
            recovered_data      <= demod;
            recovered_clock_pin <= 1'b0;
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    // Read data prepared in the address phase
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (haddr[7:0])
            `ADDR_OP_MODE:   next_rdata = {21'h0, mode_state, 3'h0, op_mode};
            `ADDR_BIT_RATE:  next_rdata = {16'h0, bit_rate_register};
            `ADDR_OOK:       next_rdata = {19'h0, ook_cfg};
            `ADDR_CORR_CTRL: next_rdata = {22'h0, fei_busy, corr_busy, 1'b0, corr_ctrl[6:1], 1'b0};
            `ADDR_RESULT:    next_rdata = {freq_correction_value, freq_error_result};
            `ADDR_CARRIER:   next_rdata = {8'h0, carrier};
            `ADDR_OFFSET:    next_rdata = {8'h0, offset_cfg};
            `ADDR_TEMP:      next_rdata = {16'h0, temp_result, 6'h0, temp_measure_running, 1'b0};
            `ADDR_TIMEOUT:   next_rdata = {15'h0, timeout_irq, timeout_cfg};
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // Address phase capture and read data
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend   <= ahb_go & hwrite;
            wr_addr   <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ahb_go & !hwrite)
                hrdata <= next_rdata;
        end
    end

    // Configuration writes
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            op_mode           <= 5'h01;
            bit_rate_register <= `BIT_RATE_RST;
            ook_cfg           <= {3'h0, `THR_PEAK, `FLOOR_RST};
            corr_ctrl         <= 7'h00;
            offset_cfg        <= 24'h000000;
            timeout_cfg       <= 16'h0000;
        end
        else if (wr_pend)
        begin
            case (wr_addr)
                `ADDR_OP_MODE:   op_mode           <= hwdata[4:0];
                `ADDR_BIT_RATE:  bit_rate_register <= hwdata[15:0];
                `ADDR_OOK:       ook_cfg           <= hwdata[12:0];
                `ADDR_CORR_CTRL: corr_ctrl         <= {hwdata[6:1], 1'b0};
                `ADDR_OFFSET:    offset_cfg        <= hwdata[23:0];
                `ADDR_TIMEOUT:   timeout_cfg       <= hwdata[15:0];
                default:         op_mode           <= op_mode;
            endcase
        end
    end

    // ----------------------------------------
    // OOK slicer
    // ----------------------------------------
    // Bit period tick shared by slicer decay, estimator and timeout
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bit_cnt  <= 16'h0000;
            bit_tick <= 1'b0;
        end
        else
        begin
            bit_tick <= (bit_cnt >= period - 16'h0001);
            if (bit_cnt >= period - 16'h0001)
                bit_cnt <= 16'h0000;
            else
                bit_cnt <= bit_cnt + 16'h0001;
        end
    end

    // Threshold choice per mode
    always @*
    begin
        next_floor = (peak > floor_thr + `PEAK_DROP) ? peak - `PEAK_DROP : floor_thr;
        case (ook_threshold_select)
            `THR_PEAK:  next_thr = next_floor;
            `THR_FIXED: next_thr = floor_thr;
            `THR_AVG:   next_thr = avg;
            default:    next_thr = floor_thr;
        endcase
    end

    // Peak with stepped decay during zeros, running average
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            peak     <= 8'h00;
            avg      <= 8'h00;
            ook_data <= 1'b0;
        end
        else
        begin
            ook_data <= (rssi >= next_thr);
            if (rssi > peak)
                peak <= rssi;
            else if (bit_tick & !ook_data & (peak > floor_thr + `PEAK_DROP))
                peak <= peak - 8'h01;
            if (rssi > avg)
                avg <= avg + ((rssi - avg) >> `AVG_SHIFT);
            else
                avg <= avg - ((avg - rssi) >> `AVG_SHIFT);
        end
    end

    // ----------------------------------------
    // Frequency error and correction
    // ----------------------------------------
    // Four bit periods of evaluation (two passes of four with low index), then carrier correction
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            freq_error_result     <= 16'sh0000;
            freq_correction_value <= 16'sh0000;
            carrier               <= 24'h000000;
            corr_busy             <= 1'b0;
            fei_busy              <= 1'b0;
            second_pass           <= 1'b0;
            eval_cnt              <= 3'h0;
            active_bandwidth      <= 8'h00;
        end
        else
        begin
            active_bandwidth <= corr_busy ? offset_cfg[15:8] : offset_cfg[23:16];
            if (wr_pend & (wr_addr == `ADDR_CARRIER))
                carrier <= hwdata[23:0];
            else if (launch & !corr_busy)
            begin
                corr_busy   <= 1'b1;
                eval_cnt    <= 3'h0;
                second_pass <= corr_ctrl[`CC_LOWIDX];
                if (corr_ctrl[`CC_AUTO] & corr_ctrl[`CC_CLEAR])
                begin
                    carrier <= carrier + {{8{freq_correction_value[15]}},
                               freq_correction_value};
                    freq_correction_value <= 16'sh0000;
                end
            end
            else if (wr_pend & (wr_addr == `ADDR_CORR_CTRL) & hwdata[`CC_FEI] & !fei_busy)
            begin
                fei_busy <= 1'b1;
                eval_cnt <= 3'h0;
            end
            else if ((corr_busy | fei_busy) & bit_tick)
            begin
                if (eval_cnt == `EVAL_BITS - 3'h1)
                begin
                    eval_cnt          <= 3'h0;
                    freq_error_result <= freq_error_in;
                    fei_busy          <= 1'b0;
                    if (corr_busy & second_pass)
                        second_pass <= 1'b0;
                    else if (corr_busy)
                    begin
                        corr_busy <= 1'b0;
                        if (corr_ctrl[`CC_LOWIDX])
                        begin
                            freq_correction_value <= freq_error_in + low_index_term;
                            carrier <= carrier - {{8{freq_error_in[15]}}, freq_error_in}
                                       - {{8{low_index_term[15]}}, low_index_term};
                        end
                        else
                        begin
                            freq_correction_value <= freq_error_in;
                            carrier <= carrier - {{8{freq_error_in[15]}}, freq_error_in};
                        end
                    end
                end
                else
                    eval_cnt <= eval_cnt + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // Temperature measurement
    // ----------------------------------------
    // Start only in standby or synthesizer; result inverted
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            temp_measure_running <= 1'b0;
            temp_cnt             <= 11'h000;
            temp_result          <= 8'h00;
            temp_adc_select      <= 1'b0;
        end
        else if (!temp_measure_running)
        begin
            if (wr_pend & (wr_addr == `ADDR_TEMP) & hwdata[`TP_START] & temp_ok)
            begin
                temp_measure_running <= 1'b1;
                temp_adc_select      <= 1'b1;
                temp_cnt             <= 11'h000;
            end
        end
        else if (temp_cnt == `TEMP_CYC)
        begin
            temp_measure_running <= 1'b0;
            temp_adc_select      <= 1'b0;
            temp_result          <= ~temp_sensor;
        end
        else
            temp_cnt <= temp_cnt + 11'h001;
    end

    // ----------------------------------------
    // Receive timeout
    // ----------------------------------------
    // 16-bit units from receive entry or threshold flag rise
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            to_cnt      <= 12'h000;
            to_phase    <= 1'b0;
            thr_last    <= 1'b0;
            timeout_irq <= 1'b0;
        end
        else
        begin
            thr_last <= signal_level_threshold_flag;
            if (mode_state != `MODE_RX)
            begin
                to_cnt   <= 12'h000;
                to_phase <= 1'b0;
            end
            else if (signal_level_threshold_flag & !thr_last & !to_phase)
            begin
                to_cnt   <= 12'h000;
                to_phase <= 1'b1;
            end
            else if (bit_tick)
                to_cnt <= to_cnt + 12'h001;
            if ((mode_state == `MODE_RX) & bit_tick & (to_cnt[3:0] == `TO_BITS) & (to_phase
                ? (timeout_cfg[15:8] != 8'h00 && to_cnt[11:4] == timeout_cfg[15:8] - 8'h01)
                : (timeout_cfg[7:0] != 8'h00 && to_cnt[11:4] == timeout_cfg[7:0] - 8'h01)))
                timeout_irq <= 1'b1;
            else if (wr_pend & (wr_addr == `ADDR_TIMEOUT) & hwdata[`TO_FLAG])
                timeout_irq <= 1'b0;
        end
    end

    // ----------------------------------------
    // Mode sequencer
    // ----------------------------------------
    // Steps up via standby and synthesizer unless disabled or the target is listen
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_state <= `MODE_STANDBY;
            last_mode  <= `MODE_STANDBY;
            seq_cnt    <= 12'h000;
        end
        else
        begin
            last_mode <= mode_state;
            if (mode_state == target)
                seq_cnt <= 12'h000;
            else if (op_mode[`OM_SEQ_OFF] | (target == `MODE_LISTEN)
                     | (target < mode_state) | (mode_state > `MODE_SYNTH))
                mode_state <= target;
            else if (seq_cnt == `SEQ_STEP_CYC)
            begin
                seq_cnt    <= 12'h000;
                mode_state <= (mode_state == `MODE_SYNTH) ? target
                              : mode_state + 3'h1;
            end
            else
                seq_cnt <= seq_cnt + 12'h001;
        end
    end
endmodule

/* logic/receiver_sync_afc_defines.vh */
// Constants for the receiver sync, correction and mode control block
`ifndef RECEIVER_SYNC_AFC_DEFINES_VH
`define RECEIVER_SYNC_AFC_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_OP_MODE   8'h00
`define ADDR_BIT_RATE  8'h04
`define ADDR_OOK       8'h08
`define ADDR_CORR_CTRL 8'h0C
`define ADDR_RESULT    8'h10
`define ADDR_CARRIER   8'h14
`define ADDR_OFFSET    8'h18
`define ADDR_TEMP      8'h1C
`define ADDR_TIMEOUT   8'h20
// ----------------------------------------
// Operating modes
// ----------------------------------------
`define MODE_SLEEP   3'h0
`define MODE_STANDBY 3'h1
`define MODE_SYNTH   3'h2
`define MODE_TX      3'h3
`define MODE_RX      3'h4
`define MODE_LISTEN  3'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OM_LISTEN    3
`define OM_SEQ_OFF   4
`define CC_START     0
`define CC_AUTO      1
`define CC_CLEAR     2
`define CC_LOWIDX    3
`define CC_FEI       4
`define CC_CONT      5
`define CC_SYNC_OFF  6
`define OOK_SEL_LO   8
`define OOK_OOK_MOD  12
`define TP_START     0
`define TO_FLAG      16
// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define BIT_RATE_RST 16'h0680
`define FLOOR_RST    8'h0C
`define THR_PEAK     2'h1
`define THR_FIXED    2'h0
`define THR_AVG      2'h2
`define PEAK_DROP    8'h0C
`define AVG_SHIFT    3
`define LOWIDX_SHIFT 3
`define EVAL_BITS    3'h4
`define TO_BITS      4'hF
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ      20
`define TEMP_US      100
`define TEMP_CYC     (`TEMP_US * `CLK_MHZ - 1)
`define SEQ_STEP_CYC 12'h03F
`endif
